// [rtl/host_port_and_output_control.sv]
/*
  non-multiplexed 16-bit host port with two bus styles, interrupt output and
  output-drive/reset control of the serial streams and external tristate
  controls. assumes a host on the pins (sampled through two flip-flops), an
  internal register space reached by the reg_* user ports, and a pll status
  input from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

// Function
// - drive enable high: streams and controls enabled
// - drive enable low: streams tristated, controls high
// - 16-bit bidirectional data bus
// - strobe style: acknowledge driven low when done
// - read/write style: ready goes low to high
// - chip select low opens an access
// - write strobe low means a write
// - strobe style: access needs strobe and select
// - read strobe low returns read data
// - 14-bit address decoded every access
// - style pin high strobe style, low read/write
// - interrupt low when pll status changes
// - reset: drivers off, defaults, counters cleared
// - controls enabled only with buffer bit set
module host_port_and_output_control
  import host_port_pkg::*;
#(
  parameter int WAKE_CYCLES = `HP_WAKE_CYCLES
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // host pins
  input wire logic chip_sel_n_in,
  input wire logic data_or_read_strobe_n_in,
  input wire logic rw_or_write_n_in,
  input wire logic host_bus_style_select_in,
  input wire logic [`HP_ADDR_W-1:0] host_address_bus_in,
  input wire logic [`HP_DATA_W-1:0] host_data_bus_in,
  output logic [`HP_DATA_W-1:0] host_data_bus_out,
  output logic host_data_bus_oe_out,
  output logic transfer_ack_out,
  output logic transfer_ack_oe_out,
  output logic irq_n_out,
  output logic irq_n_oe_out,
  // output drive control
  input wire logic output_drive_enable_in,
  input wire logic [`HP_STREAMS-1:0] stream_oe_req_in,
  input wire logic [`HP_TRI_CTRLS-1:0] tri_ctrl_req_in,
  output logic [`HP_STREAMS-1:0] serial_out_streams_oe_out,
  output logic [`HP_TRI_CTRLS-1:0] ext_tristate_ctrl_out,
  // internal register space
  output logic reg_req_out,
  output host_req_type reg_req_data_out,
  input wire logic [`HP_DATA_W-1:0] reg_rdata_in,
  input wire logic [`HP_DATA_W-1:0] ctrl_word_in,
  input wire logic pll_status_in,
  output logic ready_for_access_out
);

  // pin synchronisers: first stage read only by the second
  localparam int SYNC_W = 4 + `HP_ADDR_W + `HP_DATA_W + 1;
  // reset to the pins' idle levels: select, strobe and direction high, style
  // pin at its pull-up level, drive enable off; an all-zero reset would look
  // like a host access on the first edges after release
  localparam logic [SYNC_W-1:0] SYNC_IDLE = {4'hf, {`HP_ADDR_W{1'b0}}, {`HP_DATA_W{1'b0}}, 1'b0};
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_q <= SYNC_IDLE;
      sync2_q <= SYNC_IDLE;
    end else begin
      sync1_q <= {chip_sel_n_in, data_or_read_strobe_n_in, rw_or_write_n_in,
                  host_bus_style_select_in, host_address_bus_in, host_data_bus_in,
                  output_drive_enable_in};
      sync2_q <= sync1_q;
    end
  end

  logic cs_n_s, strobe_n_s, rw_s, style_s, ode_s;
  logic [`HP_ADDR_W-1:0] addr_s;
  logic [`HP_DATA_W-1:0] wdata_s;
  assign {cs_n_s, strobe_n_s, rw_s, style_s, addr_s, wdata_s, ode_s} = sync2_q;

  // decode the active access from the selected bus style
  logic active, is_write;
  always_comb begin
    if (style_s) begin
      active = !cs_n_s && !strobe_n_s;
      is_write = !rw_s;
    end else begin
      active = !cs_n_s && (!strobe_n_s || !rw_s);
      is_write = !rw_s;
    end
  end

  // post-reset wake counter, cleared by reset
  // the count is only reported; the pins are not gated by it
  logic [$clog2(WAKE_CYCLES+1)-1:0] wake_q;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wake_q <= '0;
    end else if (wake_q != WAKE_CYCLES[$clog2(WAKE_CYCLES+1)-1:0]) begin
      wake_q <= wake_q + 1'b1;
    end
  end
  assign ready_for_access_out = (wake_q == WAKE_CYCLES[$clog2(WAKE_CYCLES+1)-1:0]);

  // access state machine: take, wait, complete until strobe release
  // wait counts the ack delay so the register space can answer a read
  access_state_type state_q;
  logic [1:0] delay_q;
  logic rd_q;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
      delay_q <= '0;
      rd_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (active) begin
            state_q <= ST_WAIT;
            delay_q <= '0;
            rd_q <= !is_write;
          end
        end
        ST_WAIT: begin
          delay_q <= delay_q + 1'b1;
          if (delay_q == 2'(`HP_ACK_DELAY - 1)) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (!active) begin
            state_q <= ST_IDLE;
            rd_q <= 1'b0;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // one-cycle request to the register space, with the decoded address
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_req_out <= 1'b0;
      reg_req_data_out <= '0;
    end else begin
      reg_req_out <= (state_q == ST_IDLE) && active;
      if ((state_q == ST_IDLE) && active) begin
        reg_req_data_out <= '{addr: addr_s, wdata: wdata_s, write: is_write};
      end
    end
  end

  // read data captured on completion
  // sampled in every wait cycle; the value of the last one stands
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      host_data_bus_out <= '0;
    end else if (state_q == ST_WAIT && rd_q) begin
      host_data_bus_out <= reg_rdata_in;
    end
  end
  assign host_data_bus_oe_out = rd_q && !cs_n_s && !strobe_n_s;

  // completion signal: ack low in strobe style, ready rises in the other
  // strobe style releases the pin outside done, so the pull-up holds it high;
  // the other style drives it low through wait so that its rise marks the end
  logic done;
  assign done = (state_q == ST_DONE);
  always_comb begin
    if (style_s) begin
      transfer_ack_out = !done;
      transfer_ack_oe_out = done;
    end else begin
      transfer_ack_out = done;
      transfer_ack_oe_out = (state_q != ST_IDLE);
    end
  end

  // interrupt on pll status change, held until the next register read of any address;
  // pll_seen_q skips the first cycle after reset, when pll_q has no history
  logic pll_q, irq_q, pll_seen_q;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pll_q <= 1'b0;
      pll_seen_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      pll_q <= pll_status_in;
      pll_seen_q <= 1'b1;
      if (pll_seen_q && (pll_q != pll_status_in) && ctrl_word_in[`HP_IRQ_EN_BIT]) begin
        irq_q <= 1'b1;
      end else if (reg_req_out && !reg_req_data_out.write) begin
        irq_q <= 1'b0;
      end
    end
  end
  assign irq_n_out = 1'b0;
  assign irq_n_oe_out = irq_q; // open drain, low when pending

  // stream drivers follow drive enable; tristate controls follow drive enable and buffer bit
  logic streams_on, ctrl_on;
  assign streams_on = ode_s && !rst_in;
  assign ctrl_on = streams_on && ctrl_word_in[`HP_CTRL_BUF_BIT];
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      serial_out_streams_oe_out <= '0;
      ext_tristate_ctrl_out <= '1;
    end else begin
      serial_out_streams_oe_out <= streams_on ? stream_oe_req_in : '0;
      ext_tristate_ctrl_out <= ctrl_on ? tri_ctrl_req_in : '1;
    end
  end

endmodule // host_port_and_output_control

`default_nettype wire

// [rtl/host_port_cfg.svh]
/*
  constants for the host port and output control block: widths, field
  positions and timing counts. assumes a 50 MHz system clock.
*/
`ifndef HOST_PORT_CFG_SVH
`define HOST_PORT_CFG_SVH

`define HP_DATA_W 16
`define HP_ADDR_W 14
`define HP_STREAMS 32
`define HP_TRI_CTRLS 16
`define HP_CLK_PERIOD_NS 20
// reset hold and post-reset quiet times, as printed
`define HP_RESET_HOLD_NS 1000
`define HP_WAKE_US 600
// wake time in cycles, rounded down
`define HP_WAKE_CYCLES ((`HP_WAKE_US * 1000) / `HP_CLK_PERIOD_NS)
// ack delay in cycles from a taken strobe to the completion signal
`define HP_ACK_DELAY 2
// bit of the control word that holds the output-stream-buffer enable
`define HP_CTRL_BUF_BIT 2
`define HP_CTRL_RESET 16'h0000
`define HP_IRQ_EN_BIT 0

`endif

// [rtl/host_port_pkg.sv]
/*
  types shared by the host port block: the bus request bundle
  and the access state. assumes host_port_cfg.svh for the widths.
*/
`include "host_port_cfg.svh"

package host_port_pkg;

  typedef struct packed {
    logic [`HP_ADDR_W-1:0] addr;
    logic [`HP_DATA_W-1:0] wdata;
    logic write;
  } host_req_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_DONE
  } access_state_type;

endpackage

// [verification/host_model.sv]
/* host cpu model on the port pins; assumes a pull-up on the completion pin in strobe style */
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // pins seen from the host
  input wire logic sys_clk_in,
  input wire logic host_bus_style_select_in,
  input wire logic transfer_ack_out,
  input wire logic transfer_ack_oe_out,
  input wire logic [15:0] host_data_bus_out,
  input wire logic host_data_bus_oe_out,
  output logic chip_sel_n_in,
  output logic data_or_read_strobe_n_in,
  output logic rw_or_write_n_in,
  output logic [13:0] host_address_bus_in,
  output logic [15:0] host_data_bus_in
);
  // completion pin level including its pull resistor
  wire logic lvl = transfer_ack_oe_out ? transfer_ack_out : host_bus_style_select_in;
  initial {chip_sel_n_in, data_or_read_strobe_n_in, rw_or_write_n_in, host_address_bus_in, host_data_bus_in} = {3'h7, 30'h0};
  // one access; sel low leaves chip select released
  task automatic xfer(input logic w, sel, input logic [13:0] a, input logic [15:0] d, output logic [15:0] q,
    output logic ok);
    @(negedge sys_clk_in);
    {chip_sel_n_in, host_address_bus_in, host_data_bus_in} = {!sel, a, w ? d : ~d};
    rw_or_write_n_in = !w;
    data_or_read_strobe_n_in = host_bus_style_select_in ? 1'h0 : w;
    ok = 1'h0;
    for (int n = 0; n < 20 && !ok; n++) begin
      @(posedge sys_clk_in);
      ok = host_bus_style_select_in ? !lvl : lvl;
    end
    q = host_data_bus_oe_out ? host_data_bus_out : 16'hxxxx;
    @(negedge sys_clk_in);
    {chip_sel_n_in, data_or_read_strobe_n_in, rw_or_write_n_in, host_data_bus_in} = {3'h7, ~host_data_bus_in};
    repeat (5) @(negedge sys_clk_in);
  endtask
endmodule // host_model
`default_nettype wire

// [verification/host_port_and_output_control_tb.sv]
/* bench for the host port block; assumes host model on the pins, core inputs driven here */
`timescale 1ns/1ps
`default_nettype none
`include "host_port_cfg.svh"
module host_port_and_output_control_tb;
  import host_port_pkg::*;
  logic sys_clk_in = 1'h0, rst_in = 1'h1, host_bus_style_select_in = 1'h1, output_drive_enable_in = 1'h1;
  logic pll_status_in = 1'h0, ok;
  logic [31:0] stream_oe_req_in = 32'h1234abcd;
  logic [15:0] tri_ctrl_req_in = 16'h5a5a, reg_rdata_in = 16'h5aa5, ctrl_word_in = 16'h0000, q;
  wire logic chip_sel_n_in, data_or_read_strobe_n_in, rw_or_write_n_in, host_data_bus_oe_out, transfer_ack_out;
  wire logic transfer_ack_oe_out, irq_n_out, irq_n_oe_out, reg_req_out, ready_for_access_out;
  wire logic [13:0] host_address_bus_in;
  wire logic [15:0] host_data_bus_in, host_data_bus_out, ext_tristate_ctrl_out;
  wire logic [31:0] serial_out_streams_oe_out;
  wire host_req_type reg_req_data_out;
  host_req_type last_req;
  int err_count = 0, num_checks = 0;
  host_port_and_output_control #(.WAKE_CYCLES(20)) u_host_port_and_output_control (.*);
  host_model u_host_model (.*);
  initial forever #10 sys_clk_in = ~sys_clk_in;
  // keep the last request handed to the register space
  always @(posedge sys_clk_in) if (reg_req_out === 1'h1) last_req <= reg_req_data_out;
  task automatic chk(input logic [63:0] g, e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic t_reset();
    repeat (12) @(negedge sys_clk_in);
    chk({serial_out_streams_oe_out, ext_tristate_ctrl_out}, {32'h0, 16'hffff});
    repeat (`HP_RESET_HOLD_NS / `HP_CLK_PERIOD_NS - 11) @(negedge sys_clk_in);
    rst_in = 1'h0;
    for (int n = 0; n < 60 && ready_for_access_out !== 1'h1; n++) @(negedge sys_clk_in);
    chk(ready_for_access_out, 1'h1);
    $display("reset test done");
  endtask
  task automatic t_out();
    ctrl_word_in = 16'h0004;
    repeat (6) @(negedge sys_clk_in);
    chk({serial_out_streams_oe_out, ext_tristate_ctrl_out}, {stream_oe_req_in, tri_ctrl_req_in});
    output_drive_enable_in = 1'h0;
    repeat (6) @(negedge sys_clk_in);
    chk({serial_out_streams_oe_out, ext_tristate_ctrl_out}, {32'h0, 16'hffff});
    {output_drive_enable_in, ctrl_word_in} = {1'h1, 16'h0001};
    repeat (6) @(negedge sys_clk_in);
    chk(ext_tristate_ctrl_out, 16'hffff);
    $display("output control test done");
  endtask
  task automatic t_xfer(input logic s);
    host_bus_style_select_in = s;
    repeat (4) @(negedge sys_clk_in);
    u_host_model.xfer(1'h1, 1'h1, 14'h3ffd, {15'h52d2, s}, q, ok);
    chk({ok, last_req}, {1'h1, 14'h3ffd, 15'h52d2, s, 1'h1});
    u_host_model.xfer(1'h0, 1'h1, 14'h0002, 16'h0000, q, ok);
    chk({ok, q, last_req.write}, {1'h1, reg_rdata_in, 1'h0});
    chk(host_data_bus_oe_out, 1'h0);
    u_host_model.xfer(1'h1, 1'h0, 14'h0001, 16'hffff, q, ok);
    chk({ok, last_req.addr}, {1'h0, 14'h0002});
    $display("transfer test done");
  endtask
  task automatic t_irq();
    pll_status_in = 1'h1;
    repeat (6) @(negedge sys_clk_in);
    chk({irq_n_oe_out, irq_n_out}, 2'h2);
    u_host_model.xfer(1'h0, 1'h1, 14'h0010, 16'h0000, q, ok);
    chk(irq_n_oe_out, 1'h0);
    $display("interrupt test done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // main sequence, then a watchdog against hangs
  initial begin
    t_reset();
    t_out();
    t_xfer(1'h1);
    t_xfer(1'h0);
    t_irq();
    complete_run();
  end
  initial begin
    #100000;
    err_count++;
    complete_run();
  end
endmodule // host_port_and_output_control_tb
bind host_port_and_output_control host_port_checker u_host_port_checker (.*);
`default_nettype wire

// [verification/host_port_checker.sv]
/* assertions on the host port pins; assumes binding to its top module, one clock */
`timescale 1ns/1ps
`default_nettype none
module host_port_checker (
  // watched ports
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic chip_sel_n_in,
  input wire logic host_bus_style_select_in,
  input wire logic transfer_ack_out,
  input wire logic transfer_ack_oe_out,
  input wire logic host_data_bus_oe_out,
  input wire logic irq_n_oe_out,
  input wire logic output_drive_enable_in,
  input wire logic [31:0] serial_out_streams_oe_out,
  input wire logic [15:0] ext_tristate_ctrl_out,
  input wire logic reg_req_out,
  input wire logic [15:0] ctrl_word_in,
  input wire logic pll_status_in
);
  // completion pin actively driven low or high
  wire logic lo = transfer_ack_oe_out && !transfer_ack_out;
  wire logic hi = transfer_ack_oe_out && transfer_ack_out;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  chk_reset_quiet: assert property (disable iff (1'h0) rst_in |=> &ext_tristate_ctrl_out && !serial_out_streams_oe_out)
    else $error("tristate ctrl low in reset");
  chk_drive_off: assert property (!output_drive_enable_in [*4] |-> !serial_out_streams_oe_out)
    else $error("stream driven while disabled");
  chk_buf_off: assert property (!ctrl_word_in[2] [*4] |-> &ext_tristate_ctrl_out)
    else $error("tristate ctrl low without buffer bit");
  chk_ack_low: assert property (reg_req_out && host_bus_style_select_in |-> ##2 lo)
    else $error("acknowledge missing");
  chk_ready_rise: assert property (reg_req_out && !host_bus_style_select_in |-> !hi ##1 !hi ##1 hi)
    else $error("ready did not rise");
  chk_bus_quiet: assert property (chip_sel_n_in [*3] |-> !host_data_bus_oe_out)
    else $error("data bus driven while deselected");
  chk_sel_idle: assert property (chip_sel_n_in [*6] |-> !reg_req_out)
    else $error("request while deselected");
  chk_sel_taken: assert property (reg_req_out |-> !$past(chip_sel_n_in, 2))
    else $error("request without select");
  chk_irq_pll: assert property ($changed(pll_status_in) && ctrl_word_in[0] |-> ##[1:4] irq_n_oe_out)
    else $error("interrupt not raised");
endmodule // host_port_checker
`default_nettype wire
